// *** include/sil_pkg.sv ***
// package: constants, types and register map for the status lamp block
package sil_pkg;

    // ==========================================
    // avalon register map (byte addresses)
    localparam logic [7:0] SIL_ADDR_CTRL    = 8'h00;
    localparam logic [7:0] SIL_ADDR_STATUS  = 8'h04;
    localparam logic [7:0] SIL_ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] SIL_ADDR_IRQ_MSK = 8'h0C;
    localparam logic [7:0] SIL_ADDR_SWCAP   = 8'h10;
    localparam logic [7:0] SIL_ADDR_LAMPS   = 8'h14;
    localparam logic [31:0] SIL_UNMAPPED    = 32'hDEADBEEF;

    // ==========================================
    // ctrl register fields
    localparam int SIL_CTRL_HWFAULT = 0;
    localparam int SIL_CTRL_PARAM   = 1;
    localparam logic [31:0] SIL_CTRL_RST = 32'h00000000;

    // ==========================================
    // status / irq bit positions
    localparam int SIL_EV_RANGE  = 0;
    localparam int SIL_EV_CHANGE = 1;
    localparam int SIL_EV_LINK   = 2;
    localparam int SIL_EV_HW     = 3;
    localparam int SIL_EV_N      = 4;

    // ==========================================
    // lamp colour codes (two bits: {red, green})
    localparam logic [1:0] SIL_LAMP_OFF   = 2'h0;
    localparam logic [1:0] SIL_LAMP_GREEN = 2'h1;
    localparam logic [1:0] SIL_LAMP_RED   = 2'h2;

    // sensor connection states
    localparam logic [1:0] SIL_SNS_NONE  = 2'h0;
    localparam logic [1:0] SIL_SNS_OK    = 2'h1;
    localparam logic [1:0] SIL_SNS_FAULT = 2'h2;

    // ==========================================
    // timing
    localparam int SIL_CLK_MHZ       = 100;
    localparam int SIL_FLASH_HALF_MS = 250;
    localparam int SIL_FLASH_HALF_CYC = SIL_FLASH_HALF_MS * 1000 * SIL_CLK_MHZ;

    // ==========================================
    // capture state machine
    typedef enum logic [2:0] {
        SIL_ST_RESET = 3'b001,
        SIL_ST_CAPT  = 3'b010,
        SIL_ST_RUN   = 3'b100
    } sil_state_t;

endpackage : sil_pkg

// *** include/sil_flash_if.sv ***
// interface: flash timebase between top and flasher
`timescale 1ns/10ps
interface sil_flash_if;
    logic phase;
    logic tick;
    modport gen  (output phase, output tick);
    modport user (input phase, input tick);
endinterface : sil_flash_if

// *** rtl/sil_flasher.sv ***
// module: free-running flash phase generator
`timescale 1ns/10ps
module sil_flasher
    import sil_pkg::*;
#(
    parameter int HALF_CYC = SIL_FLASH_HALF_CYC
)
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // flash timebase
    sil_flash_if.gen    fl
);

    localparam int CW = $clog2(HALF_CYC + 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          ph_r;
    logic          ph_nxt;
    logic          tick_nxt;
    logic          tick_r;

    // ==========================================
    // half-period counter
    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + CW'(1);
        ph_nxt   = ph_r;
        if (cnt_r == CW'(HALF_CYC - 1))
        begin
            cnt_nxt  = '0;
            ph_nxt   = ~ph_r;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r  <= '0;
            ph_r   <= 1'b0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            ph_r   <= ph_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign fl.phase = ph_r;
    assign fl.tick  = tick_r;

endmodule : sil_flasher

// *** rtl/sil_status_lamps.sv ***
// module: front-panel status lamp logic with avalon register access
// Function
// - fault lamp steady red on bad station
// - fault lamp flashes on switch change while the link exchanges data
// - switches sampled once after power-up
// - sensor lamp follows sensor connection, dark on hardware fault
// - parameter mismatch keeps run and fault dark
// - run lamp dark without link
// - hardware fault darkens all three lamps
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module sil_status_lamps
    import sil_pkg::*;
#(
    parameter int         SW_W       = 8,
    parameter logic [7:0] STN_MIN    = 8'h01,
    parameter logic [7:0] STN_MAX    = 8'h40,
    parameter int         FLASH_HALF = SIL_FLASH_HALF_CYC
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // setting switches
    input  wire logic [SW_W-1:0]   station_sw,
    input  wire logic [3:0]        mode_sw,
    // fieldbus state
    input  wire logic              link_cable_ok,
    input  wire logic              link_exchange,
    input  wire logic              link_param_ok,
    // sensor amplifier connection
    input  wire logic [1:0]        sensor_state,
    // avalon-mm slave
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // lamps and interrupt
    output logic [1:0]             run_lamp,
    output logic [1:0]             err_lamp,
    output logic [1:0]             ss_lamp,
    output logic                   irq
);

    // ==========================================
    // flash timebase
    sil_flash_if fl ();

    sil_flasher #(
        .HALF_CYC (FLASH_HALF)
    ) u_flash (
        .clk   (clk),
        .rst_n (rst_n),
        .fl    (fl.gen)
    );

    // ==========================================
    // switch capture
    sil_state_t      st_r;
    sil_state_t      st_nxt;
    logic [SW_W-1:0] stn_cap_r;
    logic [SW_W-1:0] stn_cap_nxt;
    logic [3:0]      mode_cap_r;
    logic [3:0]      mode_cap_nxt;

    always_comb
    begin
        st_nxt       = st_r;
        stn_cap_nxt  = stn_cap_r;
        mode_cap_nxt = mode_cap_r;
        unique case (st_r)
            SIL_ST_RESET:
            begin
                st_nxt = SIL_ST_CAPT;
            end
            SIL_ST_CAPT:
            begin
                stn_cap_nxt  = station_sw;
                mode_cap_nxt = mode_sw;
                st_nxt       = SIL_ST_RUN;
            end
            SIL_ST_RUN:
            begin
                st_nxt = SIL_ST_RUN;
            end
            default:
            begin
                st_nxt = SIL_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r       <= SIL_ST_RESET;
            stn_cap_r  <= '0;
            mode_cap_r <= '0;
        end
        else
        begin
            st_r       <= st_nxt;
            stn_cap_r  <= stn_cap_nxt;
            mode_cap_r <= mode_cap_nxt;
        end
    end

    // ==========================================
    // fault conditions
    logic running;
    logic range_bad;
    logic sw_changed;
    logic hw_fault;
    logic param_bad;
    logic [7:0] stn_ext;

    assign running   = (st_r == SIL_ST_RUN);
    assign stn_ext   = 8'(stn_cap_r);
    assign range_bad = running && ((stn_ext < STN_MIN) || (stn_ext > STN_MAX));
    assign sw_changed = running && ((station_sw != stn_cap_r) || (mode_sw != mode_cap_r));

    // ==========================================
    // registers
    logic [31:0]         ctrl_r;
    logic [31:0]         ctrl_nxt;
    logic [SIL_EV_N-1:0] ist_r;
    logic [SIL_EV_N-1:0] ist_nxt;
    logic [SIL_EV_N-1:0] imsk_r;
    logic [SIL_EV_N-1:0] imsk_nxt;
    logic [SIL_EV_N-1:0] ev_lvl;
    logic [SIL_EV_N-1:0] ev_prev_r;
    logic [SIL_EV_N-1:0] ev_rise;
    logic [31:0]         rd_nxt;
    logic [31:0]         rd_r;
    logic                wait_r;
    logic                wait_nxt;
    logic                acc;

    assign hw_fault  = ctrl_r[SIL_CTRL_HWFAULT];
    assign param_bad = ctrl_r[SIL_CTRL_PARAM] || !link_param_ok;

    assign ev_lvl  = {hw_fault, !link_cable_ok, sw_changed, range_bad};
    assign ev_rise = ev_lvl & ~ev_prev_r;
    assign acc     = (avs_read || avs_write) && wait_r;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        imsk_nxt = imsk_r;
        ist_nxt  = ist_r;
        rd_nxt   = rd_r;
        wait_nxt = 1'b1;
        if (acc)
        begin
            // one wait cycle; read data registered at the take edge
            wait_nxt = 1'b0;
            rd_nxt   = 32'h00000000;
            if (!avs_write)
            begin
                unique case (avs_address)
                    SIL_ADDR_CTRL:    rd_nxt = ctrl_r;
                    SIL_ADDR_STATUS:  rd_nxt = 32'(ev_lvl);
                    SIL_ADDR_IRQ_ST:  rd_nxt = 32'(ist_r);
                    SIL_ADDR_IRQ_MSK: rd_nxt = 32'(imsk_r);
                    SIL_ADDR_SWCAP:   rd_nxt = {20'h00000, mode_cap_r, 8'(stn_cap_r)};
                    SIL_ADDR_LAMPS:   rd_nxt = {26'h0000000, ss_lamp, err_lamp, run_lamp};
                    default:          rd_nxt = SIL_UNMAPPED;
                endcase
            end
        end
        // write lands at the edge where waitrequest is seen low
        if (avs_write && !wait_r)
        begin
            unique case (avs_address)
                SIL_ADDR_CTRL:    ctrl_nxt = avs_writedata;
                SIL_ADDR_IRQ_ST:  ist_nxt  = ist_r & ~avs_writedata[SIL_EV_N-1:0];
                SIL_ADDR_IRQ_MSK: imsk_nxt = avs_writedata[SIL_EV_N-1:0];
                default:          ctrl_nxt = ctrl_r;
            endcase
        end
        // set wins over a same-cycle clear
        ist_nxt = ist_nxt | ev_rise;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r    <= SIL_CTRL_RST;
            ist_r     <= '0;
            imsk_r    <= '0;
            ev_prev_r <= '0;
            rd_r      <= 32'h00000000;
            wait_r    <= 1'b1;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            ist_r     <= ist_nxt;
            imsk_r    <= imsk_nxt;
            ev_prev_r <= ev_lvl;
            rd_r      <= rd_nxt;
            wait_r    <= wait_nxt;
        end
    end

    assign avs_readdata    = rd_r;
    assign avs_waitrequest = wait_r;

    // ==========================================
    // lamp decode
    logic [1:0] run_nxt;
    logic [1:0] err_nxt;
    logic [1:0] ss_nxt;
    logic       irq_nxt;
    logic [1:0] run_r;
    logic [1:0] err_r;
    logic [1:0] ss_r;
    logic       irq_r;

    always_comb
    begin
        run_nxt = SIL_LAMP_OFF;
        err_nxt = SIL_LAMP_OFF;
        ss_nxt  = SIL_LAMP_OFF;
        irq_nxt = |(ist_r & imsk_r);
        unique case (sensor_state)
            SIL_SNS_OK:    ss_nxt = SIL_LAMP_GREEN;
            SIL_SNS_FAULT: ss_nxt = SIL_LAMP_RED;
            default:       ss_nxt = SIL_LAMP_OFF;
        endcase
        if (!running)
        begin
            run_nxt = SIL_LAMP_OFF;
        end
        else if (hw_fault)
        begin
            ss_nxt = SIL_LAMP_OFF;
        end
        else if (range_bad)
        begin
            err_nxt = SIL_LAMP_RED;
        end
        else if (param_bad)
        begin
            err_nxt = SIL_LAMP_OFF;
        end
        else if (!link_cable_ok || !link_exchange)
        begin
            run_nxt = SIL_LAMP_OFF;
            err_nxt = (link_cable_ok) ? SIL_LAMP_OFF : SIL_LAMP_OFF;
        end
        else if (sw_changed)
        begin
            err_nxt = fl.phase ? SIL_LAMP_RED : SIL_LAMP_OFF;
        end
        else
        begin
            run_nxt = SIL_LAMP_GREEN;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_r <= SIL_LAMP_OFF;
            err_r <= SIL_LAMP_OFF;
            ss_r  <= SIL_LAMP_OFF;
            irq_r <= 1'b0;
        end
        else
        begin
            run_r <= run_nxt;
            err_r <= err_nxt;
            ss_r  <= ss_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign run_lamp = run_r;
    assign err_lamp = err_r;
    assign ss_lamp  = ss_r;
    assign irq      = irq_r;

endmodule : sil_status_lamps

// *** dv/sil_master_model.sv ***
// model: fieldbus master station reporting the link state
`timescale 1ns/10ps
module sil_master_model
#(
    parameter int LAG = 3
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // scenario: 0 exchange, 1 no cable, 2 idle, 3 param mismatch
    input  wire logic [1:0] mode,
    // link state
    output logic            link_cable_ok,
    output logic            link_exchange,
    output logic            link_param_ok
);
    int wait_r;
    // ==========================================
    // exchange starts only once the cable has been up for a while
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wait_r <= 0;
        else if (mode != 2'h0)
            wait_r <= 0;
        else if (wait_r < LAG)
            wait_r <= wait_r + 1;
    end
    assign link_cable_ok = mode != 2'h1;
    assign link_param_ok = mode != 2'h3;
    assign link_exchange = mode == 2'h0 && wait_r == LAG;
endmodule : sil_master_model

// *** dv/sil_status_lamps_sva.sv ***
// checker: lamp and bus properties of the status lamp block
`timescale 1ns/10ps
module sil_status_lamps_chk
    import sil_pkg::*;
#(
    parameter int         SW_W    = 8,
    parameter logic [7:0] STN_MIN = 8'h01,
    parameter logic [7:0] STN_MAX = 8'h40
)
(
    // clock and reset
    input wire logic            clk,
    input wire logic            rst_n,
    // switches, link and sensor
    input wire logic [SW_W-1:0] station_sw,
    input wire logic [3:0]      mode_sw,
    input wire logic            link_cable_ok,
    input wire logic            link_exchange,
    input wire logic            link_param_ok,
    input wire logic [1:0]      sensor_state,
    // bus
    input wire logic [7:0]      avs_address,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic [31:0]     avs_writedata,
    input wire logic            avs_waitrequest,
    // lamps
    input wire logic [1:0]      run_lamp,
    input wire logic [1:0]      err_lamp,
    input wire logic [1:0]      ss_lamp
);
    logic [2:0]      cnt_r;
    logic [1:0]      ctl_r;
    logic [SW_W+3:0] cap_r;
    logic [1:0]      err_q;
    logic [3:0]      fl_r;
    logic            up, rdy, bad, chg, ok;
    // ==========================================
    // shadow of start-up, control bits and capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 3'h0;
            ctl_r <= 2'h0;
            cap_r <= '0;
            err_q <= 2'h0;
            fl_r  <= 4'h0;
        end
        else
        begin
            if (cnt_r != 3'h7)
                cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h1)
                cap_r <= {mode_sw, station_sw};
            if (avs_write && !avs_waitrequest && avs_address == SIL_ADDR_CTRL)
                ctl_r <= avs_writedata[1:0];
            err_q <= err_lamp;
            fl_r  <= (!(ok && chg) || err_lamp != err_q) ? 4'h0 : fl_r + 4'h1;
        end
    end
    assign up  = cnt_r >= 3'h4;
    assign rdy = up && !ctl_r[0];
    assign bad = cap_r[SW_W-1:0] < STN_MIN || cap_r[SW_W-1:0] > STN_MAX;
    assign chg = {mode_sw, station_sw} != cap_r;
    assign ok  = rdy && !bad && !ctl_r[1] && link_param_ok && link_cable_ok && link_exchange;
    // ==========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_done;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    take_answer_a: assert property (s_take |=> s_done)
        else $error("bus answer not one cycle");
    sns_green_a: assert property (rdy && sensor_state == SIL_SNS_OK |=> ss_lamp == SIL_LAMP_GREEN)
        else $error("sensor lamp not green");
    sns_red_a: assert property (rdy && sensor_state == SIL_SNS_FAULT |=> ss_lamp == SIL_LAMP_RED)
        else $error("sensor lamp not red");
    hw_dark_a: assert property (up && ctl_r[0] |=> {run_lamp, err_lamp, ss_lamp} == 6'h00)
        else $error("lamps lit in hardware fault");
    range_red_a: assert property (rdy && bad |=> err_lamp == SIL_LAMP_RED)
        else $error("fault lamp not steady red");
    param_dark_a: assert property (rdy && !bad && (ctl_r[1] || !link_param_ok) |=>
        run_lamp == SIL_LAMP_OFF && err_lamp == SIL_LAMP_OFF) else $error("lamps lit on mismatch");
    nolink_dark_a: assert property (rdy && !bad && !(link_cable_ok && link_exchange) |=>
        run_lamp == SIL_LAMP_OFF) else $error("run lamp lit without link");
    run_green_a: assert property (ok && !chg |=> run_lamp == SIL_LAMP_GREEN)
        else $error("run lamp not green");
    flash_live_a: assert property (fl_r < 4'hC)
        else $error("fault lamp not flashing");
endmodule : sil_status_lamps_chk
bind sil_status_lamps sil_status_lamps_chk #(.SW_W(SW_W), .STN_MIN(STN_MIN), .STN_MAX(STN_MAX))
    chk_u (.clk(clk), .rst_n(rst_n), .station_sw(station_sw), .mode_sw(mode_sw),
    .link_cable_ok(link_cable_ok), .link_exchange(link_exchange), .link_param_ok(link_param_ok),
    .sensor_state(sensor_state), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .run_lamp(run_lamp), .err_lamp(err_lamp), .ss_lamp(ss_lamp));

// *** dv/test_sil_status_lamps.sv ***
// bench: directed and random checks of the status lamp block
`timescale 1ns/10ps
module test_sil_status_lamps import sil_pkg::*;;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  stn = 8'h05;
    logic [3:0]  mode_sw = 4'h3;
    logic [1:0]  cmd = 2'h0;
    logic [1:0]  sns = SIL_SNS_OK;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic [1:0]  run, err, ss;
    logic        waitreq, irq, cab, exch, par;
    logic [7:0]  stns [4] = '{8'h00, 8'h01, 8'h40, 8'h41};
    int          miscompares = 0;
    int          comparisons = 0;
    int          seed = 90;
    int          i, nr, no;
    always #5 clk = ~clk;
    sil_master_model #(.LAG(3)) mst_u (.clk(clk), .rst_n(rst_n), .mode(cmd),
        .link_cable_ok(cab), .link_exchange(exch), .link_param_ok(par));
    sil_status_lamps #(.FLASH_HALF(4)) dut_u (.clk(clk), .rst_n(rst_n), .station_sw(stn),
        .mode_sw(mode_sw), .link_cable_ok(cab), .link_exchange(exch), .link_param_ok(par),
        .sensor_state(sns), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .run_lamp(run), .err_lamp(err), .ss_lamp(ss), .irq(irq));
    // ==========================================
    // helpers
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20)
        begin
            miscompares++;
            $display("[FAIL] %0t bus answer timed out", $time);
            end_of_test;
        end
    endtask : bus
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : do_reset
    function automatic logic [1:0] exp_ss(input logic [1:0] s);
        return s == SIL_SNS_OK ? SIL_LAMP_GREEN : s == SIL_SNS_FAULT ? SIL_LAMP_RED : SIL_LAMP_OFF;
    endfunction : exp_ss
    // ==========================================
    // main sequence
    initial
    begin
        do_reset;
        bus(1'b0, SIL_ADDR_SWCAP, 32'h0);
        chk(q, 32'h0305);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, SIL_UNMAPPED);
        bus(1'b0, SIL_ADDR_CTRL, 32'h0);
        chk(q, SIL_CTRL_RST);
        $display("registers done");
        for (i = 0; i < 40; i++)
        begin
            cmd <= 2'($random(seed));
            sns <= 2'($random(seed));
            repeat (9) @(posedge clk);
            chk(ss, exp_ss(sns));
            chk(run, cmd == 2'h0 ? SIL_LAMP_GREEN : SIL_LAMP_OFF);
            if (cmd == 2'h3)
                chk(err, SIL_LAMP_OFF);
        end
        cmd <= 2'h0;
        $display("random link done");
        bus(1'b1, SIL_ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk({run, err, ss}, 6'h00);
        bus(1'b1, SIL_ADDR_CTRL, 32'h2);
        repeat (3) @(posedge clk);
        chk({run, err}, 4'h0);
        bus(1'b1, SIL_ADDR_CTRL, 32'h0);
        bus(1'b1, SIL_ADDR_IRQ_ST, 32'hF);
        repeat (3) @(posedge clk);
        chk({run, err}, 4'h4);
        $display("forced faults done");
        stn <= 8'h7F;
        repeat (4) @(posedge clk);
        chk(irq, 1'b0);
        bus(1'b1, SIL_ADDR_IRQ_MSK, 32'h2);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        bus(1'b0, SIL_ADDR_SWCAP, 32'h0);
        chk(q, 32'h0305);
        nr = 0;
        no = 0;
        repeat (24)
        begin
            @(posedge clk);
            nr += int'(err === SIL_LAMP_RED);
            no += int'(err === SIL_LAMP_OFF);
        end
        chk(32'(nr > 0 && no > 0), 32'h1);
        bus(1'b1, SIL_ADDR_IRQ_ST, 32'h2);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        $display("switch change done");
        for (i = 0; i < 4; i++)
        begin
            stn <= stns[i];
            mode_sw <= 4'(i);
            do_reset;
            bus(1'b0, SIL_ADDR_SWCAP, 32'h0);
            chk(q, {20'h0, mode_sw, stn});
            chk(err, (i == 0 || i == 3) ? SIL_LAMP_RED : SIL_LAMP_OFF);
        end
        $display("station range done");
        end_of_test;
    end
endmodule : test_sil_status_lamps
